/* File: rtl/lfsup_consts.vh */
/*
 * constants for the line and fault supervisor: time figures, derived cycle counts, state codes.
 * assumes a 20 MHz core clock; included by its bare name.
 */
`ifndef LFSUP_CONSTS_VH
`define LFSUP_CONSTS_VH

// ---------------------------------------------------------------
// time base
// ---------------------------------------------------------------
`define LFSUP_CLK_HZ 20000000
`define LFSUP_DEGLITCH_NS 600
`define LFSUP_DEGLITCH_CYC ((`LFSUP_DEGLITCH_NS * (`LFSUP_CLK_HZ / 1000000) + 999) / 1000)
`define LFSUP_BLANK_STD_MS 68
`define LFSUP_BLANK_LONG_MS 136
`define LFSUP_SOFTSTART_MS 8
`define LFSUP_BLANK_STD_CYC (`LFSUP_BLANK_STD_MS * (`LFSUP_CLK_HZ / 1000))
`define LFSUP_BLANK_LONG_CYC (`LFSUP_BLANK_LONG_MS * (`LFSUP_CLK_HZ / 1000))
`define LFSUP_SOFTSTART_CYC (`LFSUP_SOFTSTART_MS * (`LFSUP_CLK_HZ / 1000))
`define LFSUP_CONSEC_EVENTS 3'h4

// ---------------------------------------------------------------
// sequencer states
// ---------------------------------------------------------------
`define LFSUP_ST_POWERUP 3'h0
`define LFSUP_ST_SOFTSTART 3'h1
`define LFSUP_ST_RUN 3'h2
`define LFSUP_ST_HICCUP 3'h3
`define LFSUP_ST_LATCHED 3'h4

`endif

/* File: rtl/lfsup_qualifier.v */
/*
 * one fault detector path: deglitch of a comparator level and a consecutive drive-pulse counter.
 * assumes the comparator input is already synchronised to clk and drive_tick is a one-cycle pulse.
 */
`include "lfsup_consts.vh"

module lfsup_qualifier #(
    parameter DEGLITCH_CYC = `LFSUP_DEGLITCH_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire level_in,
    input wire drive_tick,
    output reg run_done_reg
);

    // ---------------------------------------------------------------
    // deglitch and event tally
    // ---------------------------------------------------------------
    reg [7:0] glitch_cnt_reg;
    reg valid_seen_reg;
    reg [2:0] run_cnt_reg;
    wire valid_now;

    assign valid_now = level_in && (glitch_cnt_reg >= DEGLITCH_CYC[7:0]);

    always @(posedge clk)
    begin
        if (!rst_n || clear)
        begin
            glitch_cnt_reg <= 8'h00;
            valid_seen_reg <= 1'b0;
            run_cnt_reg <= 3'h0;
            run_done_reg <= 1'b0;
        end
        else
        begin
            // shorter assertions restart the count and are dropped
            if (!level_in)
                glitch_cnt_reg <= 8'h00;
            else if (!valid_now)
                glitch_cnt_reg <= glitch_cnt_reg + 8'h01;
            if (drive_tick)
            begin
                if (valid_seen_reg || valid_now)
                begin
                    if (run_cnt_reg < `LFSUP_CONSEC_EVENTS)
                        run_cnt_reg <= run_cnt_reg + 3'h1;
                    if (run_cnt_reg == `LFSUP_CONSEC_EVENTS - 3'h1)
                        run_done_reg <= 1'b1;
                end
                else
                    run_cnt_reg <= 3'h0;
                valid_seen_reg <= 1'b0;
            end
            else if (valid_now)
                valid_seen_reg <= 1'b1;
        end
    end

endmodule

/* File: rtl/lfsup_top.v */
/*
 * line and fault supervisor: gates the gate drive from brown-out, supply hiccup and fault-pin detectors.
 * assumes analog comparators outside give plain levels (asynchronous) and drive_clk_tick is from clk logic.
 */
`include "lfsup_consts.vh"

// Contract
// - when the line is below its low threshold, drive stops only after the blanking timer has fully run.
// - the blanking time is 68 ms normally and 136 ms in the long option, counted while the line stays low.
// - in a brown-out, once the supply falls to the re-arm level the start-up source turns on.
// - at the start level in a brown-out the line is rechecked and switching resumes only above the restore level.
// - a qualified fault-pin level above the upper threshold latches the controller off.
// - a qualified fault-pin level below the lower threshold also latches the controller off.
// - the thermistor bias stays off at power-up and is enabled once the supply reaches the re-arm level.
// - the lower-threshold detector is ignored during soft-start.
// - thermistor bias is doubled for the whole soft-start and nominal after it.
// - soft-start lasts 8 ms and runs on every new start and every auto-recovery restart.
// - a detector level counts only if it lasts at least 600 ns, shorter ones are dropped.
// - latch-off needs validated events on 4 consecutive drive clock pulses.
// - on latch-off the drive stops at once and the supply hiccups between start and re-arm levels.
// - the latched state clears only on supply below the clear level or a brown-out recovery.
// - a build option makes fault-pin protection auto-recovering through the hiccup cycle.
module lfsup_top #(
    parameter LONG_BLANK = 0,
    parameter AUTO_RECOVER = 0,
    parameter DEGLITCH_CYC = `LFSUP_DEGLITCH_CYC,
    parameter BLANK_STD_CYC = `LFSUP_BLANK_STD_CYC,
    parameter BLANK_LONG_CYC = `LFSUP_BLANK_LONG_CYC,
    parameter SOFTSTART_CYC = `LFSUP_SOFTSTART_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire line_below_low,
    input wire line_above_restore,
    input wire supply_at_rearm,
    input wire supply_at_start,
    input wire supply_below_clear,
    input wire fault_above_upper,
    input wire fault_below_lower,
    input wire drive_clk_tick,
    input wire pwm_request,
    output reg gate_drive_output_reg,
    output reg startup_source_on_reg,
    output reg thermistor_bias_on_reg,
    output reg thermistor_bias_double_reg,
    output reg soft_start_active_reg,
    output reg latched_off_reg,
    output reg line_undervoltage_reg
);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    reg [6:0] sync1_reg;
    reg [6:0] sync2_reg;
    reg line_ok_prev_reg;
    wire line_low = sync2_reg[0];
    wire line_ok = sync2_reg[1];
    wire at_rearm = sync2_reg[2];
    wire at_start = sync2_reg[3];
    wire below_clear = sync2_reg[4];
    wire ovp_lvl = sync2_reg[5];
    wire otp_lvl = sync2_reg[6];

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end
        else
        begin
            sync1_reg <= {fault_below_lower, fault_above_upper, supply_below_clear, supply_at_start,
                          supply_at_rearm, line_above_restore, line_below_low};
            sync2_reg <= sync1_reg;
        end
    end

    // ---------------------------------------------------------------
    // state, timers
    // ---------------------------------------------------------------
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [22:0] timer_reg;
    reg [22:0] blank_reg;
    reg blank_done_reg;
    reg bo_recover_reg;
    wire [22:0] blank_len = LONG_BLANK ? BLANK_LONG_CYC[22:0] : BLANK_STD_CYC[22:0];
    wire ovp_run;
    wire otp_run;
    wire in_soft = (state_reg == `LFSUP_ST_SOFTSTART);
    wire fault_hit = ovp_run || otp_run;
    wire restart_ok = at_start && line_ok && !line_low;
    // detectors tally only while pulses may run, so a stale run cannot re-trip a fresh start
    wire ovp_clear = !(in_soft || (state_reg == `LFSUP_ST_RUN));
    wire otp_clear = (state_reg != `LFSUP_ST_RUN);

    lfsup_qualifier #(.DEGLITCH_CYC(DEGLITCH_CYC)) u_ovp (
        .clk(clk),
        .rst_n(rst_n),
        .clear(ovp_clear),
        .level_in(ovp_lvl),
        .drive_tick(drive_clk_tick),
        .run_done_reg(ovp_run)
    );

    lfsup_qualifier #(.DEGLITCH_CYC(DEGLITCH_CYC)) u_otp (
        .clk(clk),
        .rst_n(rst_n),
        .clear(otp_clear),
        .level_in(otp_lvl),
        .drive_tick(drive_clk_tick),
        .run_done_reg(otp_run)
    );

    // brown-out blanking counts only while the line stays low
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            blank_reg <= 23'h000000;
            blank_done_reg <= 1'b0;
            line_ok_prev_reg <= 1'b0;
            bo_recover_reg <= 1'b0;
        end
        else
        begin
            line_ok_prev_reg <= line_ok;
            bo_recover_reg <= line_ok && !line_ok_prev_reg && line_undervoltage_reg;
            if (!line_low)
            begin
                blank_reg <= 23'h000000;
                blank_done_reg <= 1'b0;
            end
            else if (blank_reg < blank_len - 23'h000001)
                blank_reg <= blank_reg + 23'h000001;
            else
                blank_done_reg <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            `LFSUP_ST_POWERUP:
                if (restart_ok)
                    state_next = `LFSUP_ST_SOFTSTART;
            `LFSUP_ST_SOFTSTART, `LFSUP_ST_RUN:
            begin
                if (fault_hit)
                    state_next = AUTO_RECOVER ? `LFSUP_ST_HICCUP : `LFSUP_ST_LATCHED;
                else if (blank_done_reg)
                    state_next = `LFSUP_ST_HICCUP;
                else if (in_soft && timer_reg >= SOFTSTART_CYC[22:0] - 23'h000001)
                    state_next = `LFSUP_ST_RUN;
            end
            `LFSUP_ST_HICCUP:
                if (restart_ok)
                    state_next = `LFSUP_ST_SOFTSTART;
            `LFSUP_ST_LATCHED:
                if (below_clear || bo_recover_reg)
                    state_next = `LFSUP_ST_POWERUP;
            default:
                state_next = `LFSUP_ST_POWERUP;
        endcase
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= `LFSUP_ST_POWERUP;
            timer_reg <= 23'h000000;
            gate_drive_output_reg <= 1'b0;
            startup_source_on_reg <= 1'b1;
            thermistor_bias_on_reg <= 1'b0;
            thermistor_bias_double_reg <= 1'b0;
            soft_start_active_reg <= 1'b0;
            latched_off_reg <= 1'b0;
            line_undervoltage_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= (state_next == `LFSUP_ST_SOFTSTART && in_soft) ? timer_reg + 23'h000001 : 23'h000000;
            // drive is gated in the same edge the state leaves run
            gate_drive_output_reg <= pwm_request &&
                (state_next == `LFSUP_ST_SOFTSTART || state_next == `LFSUP_ST_RUN);
            // hiccup: source on once the supply has fallen below re-arm, off at start level
            if (state_next == `LFSUP_ST_SOFTSTART || state_next == `LFSUP_ST_RUN)
                startup_source_on_reg <= 1'b0;
            else if (!at_rearm)
                startup_source_on_reg <= 1'b1;
            else if (at_start)
                startup_source_on_reg <= 1'b0;
            if (state_next == `LFSUP_ST_POWERUP && !at_rearm && !at_start)
                thermistor_bias_on_reg <= 1'b0;
            else if (at_rearm || at_start)
                thermistor_bias_on_reg <= 1'b1;
            thermistor_bias_double_reg <= (state_next == `LFSUP_ST_SOFTSTART);
            soft_start_active_reg <= (state_next == `LFSUP_ST_SOFTSTART);
            latched_off_reg <= (state_next == `LFSUP_ST_LATCHED);
            if (blank_done_reg)
                line_undervoltage_reg <= 1'b1;
            else if (line_ok && !line_low)
                line_undervoltage_reg <= 1'b0;
        end
    end

endmodule

/* File: verif/lfsup_checker.sv */
/* port assertions for lfsup_top; bound to every instance of it */
module lfsup_checker #(parameter SOFTSTART_CYC = 100, parameter BLANK_STD_CYC = 200) (
    input logic clk, rst_n, line_below_low, line_above_restore, supply_at_rearm,
    input logic supply_at_start, supply_below_clear, fault_above_upper, fault_below_lower,
    input logic drive_clk_tick, pwm_request, gate_drive_output_reg, startup_source_on_reg,
    input logic thermistor_bias_on_reg, thermistor_bias_double_reg, soft_start_active_reg,
    input logic latched_off_reg, line_undervoltage_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    int ss_cnt, lo_cnt;
    logic [2:0] ev;
    logic [3:0] rel;
    logic restore_prev;
    logic seen;
    wire flt = fault_above_upper | fault_below_lower;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // helper counts
    // ----------------------------------------
    always @(posedge clk)
    begin
        ss_cnt <= soft_start_active_reg ? ss_cnt + 1 : 0;
        lo_cnt <= line_below_low ? lo_cnt + 1 : 0;
        restore_prev <= line_above_restore;
        rel <= {rel[2:0], supply_below_clear | (line_above_restore & !restore_prev)};
        if (!rst_n)
            {seen, ev} <= 4'h0;
        else
        begin
            seen <= !drive_clk_tick && (seen || flt);
            if (drive_clk_tick)
                ev <= (seen || flt) ? ev + {2'h0, ev != 3'h7} : 3'h0;
        end
    end
    sequence s_ss_end;
        $fell(soft_start_active_reg) && !latched_off_reg;
    endsequence
    a_softstart_len: assert property (s_ss_end |-> ss_cnt == SOFTSTART_CYC)
        else $error("soft-start length off");
    a_latch_no_drive: assert property (latched_off_reg |-> !gate_drive_output_reg)
        else $error("drive while latched");
    a_uv_no_drive: assert property (line_undervoltage_reg |-> !gate_drive_output_reg)
        else $error("drive in brown-out");
    a_drive_follows_pwm: assert property (gate_drive_output_reg |-> $past(pwm_request))
        else $error("drive without request");
    a_bias_double_ss: assert property (thermistor_bias_double_reg == soft_start_active_reg)
        else $error("bias doubling off soft-start");
    a_bias_after_rearm: assert property ($rose(thermistor_bias_on_reg) |->
        $past(supply_at_rearm, 2) || $past(supply_at_rearm, 3) || $past(supply_at_rearm, 4))
        else $error("bias before re-arm");
    a_latch_needs_run: assert property ($rose(latched_off_reg) |-> ev >= 3'h4)
        else $error("latch before four ticks");
    a_latch_release: assert property ($fell(latched_off_reg) |-> |rel)
        else $error("latch cleared without cause");
    a_uv_after_blank: assert property ($rose(line_undervoltage_reg) |-> lo_cnt >= BLANK_STD_CYC)
        else $error("brown-out before blanking");
endmodule
bind lfsup_top lfsup_checker #(.SOFTSTART_CYC(SOFTSTART_CYC), .BLANK_STD_CYC(BLANK_STD_CYC)) u_chk (.*);

/* File: verif/lfsup_power_model.sv */
/* power stage model: supply capacitor, drive clock and modulator; expects one clk domain */
module lfsup_power_model #(parameter REARM = 100, parameter START = 120, parameter CLEAR = 20) (
    input logic clk, unplug, startup_source_on_reg, gate_drive_output_reg,
    output logic supply_at_rearm, supply_at_start, supply_below_clear, drive_clk_tick, pwm_request
);
    timeunit 1ns;
    timeprecision 1ns;
    int vcc = 0;
    int aux = 0;
    logic [3:0] ph = 4'h0;
    // aux winding holds the supply only while drive pulses come
    always @(negedge clk)
    begin
        ph <= ph + 4'h1;
        if (gate_drive_output_reg === 1'b1)
            aux <= 8;
        else if (aux > 0)
            aux <= aux - 1;
        if (unplug)
            vcc <= 0;
        else if (startup_source_on_reg === 1'b1 && vcc < 150)
            vcc <= vcc + 1;
        else if (aux == 0 && vcc > 0)
            vcc <= vcc - 1;
    end
    assign supply_at_rearm = vcc >= REARM;
    assign supply_at_start = vcc >= START;
    assign supply_below_clear = vcc < CLEAR;
    assign drive_clk_tick = ph == 4'h0;
    assign pwm_request = ph[1];
endmodule

/* File: verif/testbench.sv */
/* self-checking bench for lfsup_top; power stage model drives supply, ticks and pwm */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, line_below_low = 0, line_above_restore = 1, unplug = 0;
    logic fault_above_upper = 0, fault_below_lower = 0;
    logic supply_at_rearm, supply_at_start, supply_below_clear, drive_clk_tick, pwm_request;
    logic gate_drive_output_reg, startup_source_on_reg, thermistor_bias_on_reg;
    logic thermistor_bias_double_reg, soft_start_active_reg, latched_off_reg, line_undervoltage_reg;
    int mismatches = 0, n_tests = 0, cyc = 0;
    always #25 clk = ~clk;
    lfsup_top #(.BLANK_STD_CYC(200), .BLANK_LONG_CYC(400), .SOFTSTART_CYC(100)) uut (.*);
    lfsup_power_model model (.*);
    // auto-recovery build sharing the same pins; its outputs do not load the power model
    logic ar_ss, ar_latched;
    lfsup_top #(.AUTO_RECOVER(1), .BLANK_STD_CYC(200), .BLANK_LONG_CYC(400), .SOFTSTART_CYC(100)) uut_ar (
        .clk(clk), .rst_n(rst_n), .line_below_low(line_below_low), .line_above_restore(line_above_restore),
        .supply_at_rearm(supply_at_rearm), .supply_at_start(supply_at_start),
        .supply_below_clear(supply_below_clear), .fault_above_upper(fault_above_upper),
        .fault_below_lower(fault_below_lower), .drive_clk_tick(drive_clk_tick), .pwm_request(pwm_request),
        .gate_drive_output_reg(), .startup_source_on_reg(), .thermistor_bias_on_reg(),
        .thermistor_bias_double_reg(), .soft_start_active_reg(ar_ss), .latched_off_reg(ar_latched),
        .line_undervoltage_reg());
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input string nm, input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, seen);
        end
    endtask
    task automatic wait_val(input string nm, ref logic s, input logic v, input int n);
        int i;
        for (i = 0; i < n && s !== v; i++)
            @(negedge clk);
        chk(nm, s, v);
    endtask
    task automatic set_f(input logic ovp, input logic v);
        if (ovp)
            fault_above_upper = v;
        else
            fault_below_lower = v;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_startup;
        chk("bias_off", thermistor_bias_on_reg, 1'b0);
        chk("src_on", startup_source_on_reg, 1'b1);
        wait_val("bias_on", thermistor_bias_on_reg, 1'b1, 150);
        chk("below_start", supply_at_start, 1'b0);
        wait_val("ss_on", soft_start_active_reg, 1'b1, 60);
        chk("bias_x2", thermistor_bias_double_reg, 1'b1);
        wait_val("ss_off", soft_start_active_reg, 1'b0, 120);
        chk("bias_x1", thermistor_bias_double_reg, 1'b0);
        wait_val("drv_pulse", gate_drive_output_reg, 1'b1, 8);
    endtask
    task t_brownout;
        logic bad;
        bad = 0;
        line_below_low = 1;
        line_above_restore = 0;
        repeat (190) @(negedge clk);
        chk("uv_early", line_undervoltage_reg, 1'b0);
        wait_val("uv_set", line_undervoltage_reg, 1'b1, 30);
        wait_val("src_rearm", startup_source_on_reg, 1'b1, 100);
        chk("src_below_rearm", supply_at_rearm, 1'b0);
        repeat (300)
        begin
            @(negedge clk);
            bad |= soft_start_active_reg;
        end
        chk("no_restart", bad, 1'b0);
        line_below_low = 0;
        line_above_restore = 1;
        wait_val("restart", soft_start_active_reg, 1'b1, 100);
        wait_val("ss_end", soft_start_active_reg, 1'b0, 120);
    endtask
    task automatic t_fault(input logic ovp);
        repeat (6)
        begin
            set_f(ovp, 1'b1);
            repeat (8) @(negedge clk);
            set_f(ovp, 1'b0);
            repeat (8) @(negedge clk);
        end
        chk("glitch", latched_off_reg, 1'b0);
        set_f(ovp, 1'b1);
        repeat (44) @(negedge clk);
        set_f(ovp, 1'b0);
        repeat (40) @(negedge clk);
        set_f(ovp, 1'b1);
        repeat (44) @(negedge clk);
        chk("run_broken", latched_off_reg, 1'b0);
        wait_val("latch", latched_off_reg, 1'b1, 60);
        chk("drv_off", gate_drive_output_reg, 1'b0);
        set_f(ovp, 1'b0);
        wait_val("hiccup", startup_source_on_reg, 1'b1, 100);
        chk("hiccup_below_rearm", supply_at_rearm, 1'b0);
        wait_val("ar_restart", ar_ss, 1'b1, 200);
        chk("ar_no_latch", ar_latched, 1'b0);
    endtask
    task t_release;
        repeat (200) @(negedge clk);
        chk("held", latched_off_reg, 1'b1);
        unplug = 1;
        repeat (4) @(negedge clk);
        unplug = 0;
        wait_val("unlatched", latched_off_reg, 1'b0, 20);
        wait_val("ss_again", soft_start_active_reg, 1'b1, 200);
        fault_below_lower = 1;
        repeat (80) @(negedge clk);
        fault_below_lower = 0;
        repeat (100) @(negedge clk);
        chk("otp_ignored", latched_off_reg, 1'b0);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            final_report;
        end
    end
    initial
    begin
        repeat (6) @(negedge clk);
        rst_n = 1;
        t_startup;
        t_brownout;
        t_fault(1'b0);
        t_release;
        t_fault(1'b1);
        final_report;
    end
endmodule
